// *** design/msr_mem_if.sv ***
/*
 * Single-port request bundle between the router and its on-chip RAMs.
 * Assumes the RAM answers read data one clock after the request.
 */
`timescale 1ns/100ps
interface msr_mem_if #(parameter int AW = 10);
    logic          req;
    logic          we;
    logic [AW-1:0] addr;
    logic [7:0]    wdata;
    logic [7:0]    rdata;

    modport ctrl (output req, output we, output addr, output wdata, input rdata);
    modport mem  (input req, input we, input addr, input wdata, output rdata);
endinterface

// *** design/msr_pkg.sv ***
/*
 * Shared constants of the memory-space router: register indices, field
 * positions, reset values, address limits and external bus timing.
 * Assumes a 100 MHz core clock.
 */
package msr_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_ROUTE_STATUS   = 8'h00;
    localparam logic [7:0] IDX_PORT0_LATCH    = 8'h80;
    localparam logic [7:0] IDX_POINTER0_LOW   = 8'h82;
    localparam logic [7:0] IDX_POINTER0_HIGH  = 8'h83;
    localparam logic [7:0] IDX_POINTER1_LOW   = 8'h84;
    localparam logic [7:0] IDX_POINTER1_HIGH  = 8'h85;
    localparam logic [7:0] IDX_POINTER_CHOICE = 8'h86;
    localparam logic [7:0] IDX_PORT2_LATCH    = 8'hA0;
    localparam logic [7:0] IDX_PROGRAM_SIZE   = 8'hC2;
    localparam logic [7:0] IDX_POWER_MGMT     = 8'hC4;

    // Field positions
    localparam int POINTER_SEL_BIT   = 0;
    localparam int DATA_SRAM_EN_LO   = 0;
    localparam int DATA_SRAM_EN_HI   = 1;
    localparam int CLK_DIV_LSB       = 6;
    localparam int PROG_SIZE_WIDTH   = 3;

    // Reset values
    localparam logic [7:0] PORT_LATCH_RST  = 8'hFF;
    localparam logic [7:0] POINTER_RST     = 8'h00;
    localparam logic [2:0] PROG_SIZE_RST   = 3'h5;
    localparam logic [1:0] CLK_DIV_RST     = 2'h1;
    localparam logic [1:0] DATA_SRAM_RST   = 2'h0;

    // Address space limits
    localparam logic [15:0] PROG_SPACE_TOP = 16'h3FFF;
    localparam logic [15:0] DATA_SRAM_TOP  = 16'h03FF;
    localparam int          DATA_SRAM_AW   = 10;
    localparam int          DIRECT_RAM_AW  = 8;

    // External bus timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_PHASE_NS = 20;
    localparam int STROBE_NS     = 40;
    localparam logic [2:0] ADDR_CYCLES   = 3'((ADDR_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] STROBE_CYCLES = 3'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Number of bytes of internal program space for a size code
    function automatic logic [16:0] prog_limit(input logic [2:0] code);
        logic [16:0] lim;
        lim = 17'h00000;
        unique case (code)
            3'h0:    lim = 17'h00000;
            3'h1:    lim = 17'h00400;
            3'h2:    lim = 17'h00800;
            3'h3:    lim = 17'h01000;
            3'h4:    lim = 17'h02000;
            default: lim = {1'b0, PROG_SPACE_TOP} + 17'h00001;
        endcase
        return lim;
    endfunction

endpackage

// *** design/msr_ram.sv ***
/*
 * Flip-flop RAM of 2**AW bytes with a registered read port.
 * Assumes the requester holds its request for one clock per access.
 */
`timescale 1ns/100ps
module msr_ram #(
    parameter int AW = 10
) (
    input  wire logic pclk,
    input  wire logic presetn,
    msr_mem_if.mem    port
);

    logic [7:0] store_reg [0:(1<<AW)-1];
    logic [7:0] rdata_reg;

    always_ff @(posedge pclk) begin
        if (port.req && port.we) begin
            store_reg[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 8'h00;
        end else if (port.req) begin
            rdata_reg <= port.we ? port.wdata : store_reg[port.addr];
        end
    end

    assign port.rdata = rdata_reg;
endmodule

// *** design/msr_router.sv ***
/*
 * Memory-space router: program fetch and external-data move routing,
 * multiplexed external bus on the low and high address ports, program and
 * data strobes, on-chip data SRAM and direct RAM, APB register file.
 * Assumes pins arrive asynchronously and the core holds a request until done.
 */
`timescale 1ns/100ps
// Overview of operation
// R1 - Program space is 16kB internal; fetches above the configured size go external.
// R2 - Shrinking the program size sends the very next fetch above it external.
// R3 - Software should change program size only from code unaffected by the change.
// R4 - External access puts low address and data on port 0, high address on port 2.
// R5 - While the bus runs, ports 0 and 2 do not act as general I/O.
// R6 - External-fetch force input at 0 sends every fetch off-chip.
// R7 - Program fetch strobe goes low during external program fetches.
// R8 - 256 bytes of direct RAM are kept apart from the on-chip data SRAM.
// R9 - 1kB on-chip data SRAM sits at 0000h to 03FFh of external data space.
// R10 - Data SRAM is optional; when enabled, moves in its range go to it.
// R11 - Data moves above 03FFh go to the external bus.
// R12 - With the data SRAM disabled, every data move goes to the external bus.
// R13 - Program fetch strobe stays high when no external fetch is running.
// R14 - External data writes strobe port 3 bit 6, reads port 3 bit 7, low.
module msr_router
    import msr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fetch_valid,
    input  wire logic [15:0] fetch_addr,
    output logic             fetch_done,
    output logic             fetch_internal,
    output logic      [7:0]  fetch_data,
    input  wire logic        dmove_valid,
    input  wire logic        dmove_write,
    input  wire logic [7:0]  dmove_wdata,
    output logic             dmove_done,
    output logic      [7:0]  dmove_rdata,
    input  wire logic        direct_valid,
    input  wire logic        direct_write,
    input  wire logic [7:0]  direct_addr,
    input  wire logic [7:0]  direct_wdata,
    output logic      [7:0]  direct_rdata,
    input  wire logic        external_fetch_force_n,
    output logic             program_fetch_strobe_n,
    output logic             addr_latch_enable,
    input  wire logic [7:0]  low_addr_data_port_in,
    output logic      [7:0]  low_addr_data_port_out,
    output logic      [7:0]  low_addr_data_port_oe_n,
    output logic      [7:0]  high_addr_port_out,
    output logic      [7:0]  high_addr_port_oe_n,
    output logic             data_write_strobe_n,
    output logic             data_read_strobe_n
);

    typedef enum logic [1:0] {ST_IDLE, ST_INT, ST_ADDR, ST_STROBE} msr_state_e;

    msr_state_e  state_reg;
    logic [2:0]  cnt_reg;
    logic        kind_fetch_reg;
    logic        bus_write_reg;
    logic [15:0] bus_addr_reg;
    logic [7:0]  bus_wdata_reg;
    logic [7:0]  port0_latch_reg;
    logic [7:0]  port2_latch_reg;
    logic [7:0]  pointer0_low_reg;
    logic [7:0]  pointer0_high_reg;
    logic [7:0]  pointer1_low_reg;
    logic [7:0]  pointer1_high_reg;
    logic        pointer_sel_reg;
    logic [2:0]  prog_size_reg;
    logic [1:0]  clk_div_reg;
    logic [1:0]  data_sram_en_reg;
    logic        force_meta_reg;
    logic        force_sync_reg;
    logic [7:0]  p0_meta_reg;
    logic [7:0]  p0_sync_reg;
    logic        fetch_done_reg;
    logic        fetch_int_reg;
    logic [7:0]  fetch_data_reg;
    logic        dmove_done_reg;
    logic [7:0]  dmove_rdata_reg;
    logic        last_move_int_reg;
    logic [31:0] prdata_reg;
    logic        slverr_reg;

    logic [15:0] move_addr;
    logic        sram_enabled;
    logic        fetch_is_int;
    logic        move_is_int;
    logic        accept_move;
    logic        accept_fetch;
    logic        bus_active;
    logic        last_strobe;
    logic        apb_write;
    logic [7:0]  reg_index;
    logic        index_hit;
    logic [7:0]  read_value;

    msr_mem_if #(.AW(DATA_SRAM_AW))  xram_if ();
    msr_mem_if #(.AW(DIRECT_RAM_AW)) dram_if ();

    // R9 - on-chip data SRAM
    msr_ram #(.AW(DATA_SRAM_AW)) u_data_sram (
        .pclk    (pclk),
        .presetn (presetn),
        .port    (xram_if)
    );

    // R8 - separate direct RAM
    msr_ram #(.AW(DIRECT_RAM_AW)) u_direct_ram (
        .pclk    (pclk),
        .presetn (presetn),
        .port    (dram_if)
    );

    assign dram_if.req   = direct_valid;
    assign dram_if.we    = direct_write;
    assign dram_if.addr  = direct_addr;
    assign dram_if.wdata = direct_wdata;
    assign direct_rdata  = dram_if.rdata;

    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_meta_reg <= 1'b1;
            force_sync_reg <= 1'b1;
            p0_meta_reg    <= 8'h00;
            p0_sync_reg    <= 8'h00;
        end else begin
            force_meta_reg <= external_fetch_force_n;
            force_sync_reg <= force_meta_reg;
            p0_meta_reg    <= low_addr_data_port_in;
            p0_sync_reg    <= p0_meta_reg;
        end
    end

    assign move_addr    = pointer_sel_reg ? {pointer1_high_reg, pointer1_low_reg}
                                          : {pointer0_high_reg, pointer0_low_reg};
    assign sram_enabled = |data_sram_en_reg;

    // R1 R2 R6 - fetch routing from the live size and force level
    assign fetch_is_int = force_sync_reg && ({1'b0, fetch_addr} < prog_limit(prog_size_reg));

    // R10 R11 R12 - data move routing
    assign move_is_int  = sram_enabled && (move_addr <= DATA_SRAM_TOP);

    assign accept_move  = (state_reg == ST_IDLE) && !fetch_done_reg && !dmove_done_reg && dmove_valid;
    assign accept_fetch = (state_reg == ST_IDLE) && !fetch_done_reg && !dmove_done_reg
                          && fetch_valid && !dmove_valid;
    assign bus_active   = (state_reg == ST_ADDR) || (state_reg == ST_STROBE);
    assign last_strobe  = (state_reg == ST_STROBE) && (cnt_reg == STROBE_CYCLES - 3'h1);

    assign xram_if.req   = accept_move && move_is_int;
    assign xram_if.we    = dmove_write;
    assign xram_if.addr  = move_addr[DATA_SRAM_AW-1:0];
    assign xram_if.wdata = dmove_wdata;

    // Access sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg      <= ST_IDLE;
            cnt_reg        <= 3'h0;
            kind_fetch_reg <= 1'b0;
            bus_write_reg  <= 1'b0;
            bus_addr_reg   <= 16'h0000;
            bus_wdata_reg  <= 8'h00;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= 3'h0;
                    if (accept_move) begin
                        kind_fetch_reg <= 1'b0;
                        bus_write_reg  <= dmove_write;
                        bus_addr_reg   <= move_addr;
                        bus_wdata_reg  <= dmove_wdata;
                        state_reg      <= move_is_int ? ST_INT : ST_ADDR;
                    end else if (accept_fetch) begin
                        kind_fetch_reg <= 1'b1;
                        bus_write_reg  <= 1'b0;
                        bus_addr_reg   <= fetch_addr;
                        state_reg      <= fetch_is_int ? ST_INT : ST_ADDR;
                    end
                end
                ST_INT: begin
                    state_reg <= ST_IDLE;
                end
                ST_ADDR: begin
                    if (cnt_reg == ADDR_CYCLES - 3'h1) begin
                        cnt_reg   <= 3'h0;
                        state_reg <= ST_STROBE;
                    end else begin
                        cnt_reg <= cnt_reg + 3'h1;
                    end
                end
                ST_STROBE: begin
                    if (last_strobe) begin
                        cnt_reg   <= 3'h0;
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + 3'h1;
                    end
                end
            endcase
        end
    end

    // Completion toward the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_done_reg    <= 1'b0;
            fetch_int_reg     <= 1'b0;
            fetch_data_reg    <= 8'h00;
            dmove_done_reg    <= 1'b0;
            dmove_rdata_reg   <= 8'h00;
            last_move_int_reg <= 1'b0;
        end else begin
            fetch_done_reg <= 1'b0;
            dmove_done_reg <= 1'b0;
            if (state_reg == ST_INT) begin
                if (kind_fetch_reg) begin
                    fetch_done_reg <= 1'b1;
                    fetch_int_reg  <= 1'b1;
                    fetch_data_reg <= 8'h00;
                end else begin
                    dmove_done_reg    <= 1'b1;
                    dmove_rdata_reg   <= xram_if.rdata;
                    last_move_int_reg <= 1'b1;
                end
            end else if (last_strobe) begin
                if (kind_fetch_reg) begin
                    fetch_done_reg <= 1'b1;
                    fetch_int_reg  <= 1'b0;
                    fetch_data_reg <= p0_sync_reg;
                end else begin
                    dmove_done_reg    <= 1'b1;
                    dmove_rdata_reg   <= bus_write_reg ? bus_wdata_reg : p0_sync_reg;
                    last_move_int_reg <= 1'b0;
                end
            end
        end
    end

    assign fetch_done     = fetch_done_reg;
    assign fetch_internal = fetch_int_reg;
    assign fetch_data     = fetch_data_reg;
    assign dmove_done     = dmove_done_reg;
    assign dmove_rdata    = dmove_rdata_reg;

    // R4 R5 - bus owns ports 0 and 2 while active, latches otherwise
    always_comb begin
        if (state_reg == ST_ADDR) begin
            low_addr_data_port_out  = bus_addr_reg[7:0];
            low_addr_data_port_oe_n = 8'h00;
        end else if (state_reg == ST_STROBE) begin
            low_addr_data_port_out  = bus_wdata_reg;
            low_addr_data_port_oe_n = bus_write_reg ? 8'h00 : 8'hFF;
        end else begin
            low_addr_data_port_out  = port0_latch_reg;
            low_addr_data_port_oe_n = port0_latch_reg;
        end
    end

    assign high_addr_port_out  = bus_active ? bus_addr_reg[15:8] : port2_latch_reg;
    assign high_addr_port_oe_n = bus_active ? 8'h00 : port2_latch_reg;
    assign addr_latch_enable   = (state_reg == ST_ADDR);

    // R7 R13 - program strobe only in external fetch strobe phase
    assign program_fetch_strobe_n = !((state_reg == ST_STROBE) && kind_fetch_reg);

    // R14 - data strobes on port 3 bits 6 and 7
    assign data_write_strobe_n = !((state_reg == ST_STROBE) && !kind_fetch_reg && bus_write_reg);
    assign data_read_strobe_n  = !((state_reg == ST_STROBE) && !kind_fetch_reg && !bus_write_reg);

    // APB slave: read data captured in setup, one access cycle
    assign reg_index = paddr[9:2];
    assign apb_write = psel && penable && pwrite;
    assign pready    = penable;
    assign prdata    = prdata_reg;
    assign pslverr   = slverr_reg && psel && penable;

    always_comb begin
        index_hit  = 1'b1;
        read_value = 8'h00;
        unique case (reg_index)
            IDX_ROUTE_STATUS:   read_value = {4'h0, force_sync_reg, bus_active, last_move_int_reg, fetch_int_reg};
            IDX_PORT0_LATCH:    read_value = port0_latch_reg;
            IDX_POINTER0_LOW:   read_value = pointer0_low_reg;
            IDX_POINTER0_HIGH:  read_value = pointer0_high_reg;
            IDX_POINTER1_LOW:   read_value = pointer1_low_reg;
            IDX_POINTER1_HIGH:  read_value = pointer1_high_reg;
            IDX_POINTER_CHOICE: read_value = {7'h00, pointer_sel_reg};
            IDX_PORT2_LATCH:    read_value = port2_latch_reg;
            IDX_PROGRAM_SIZE:   read_value = {5'h00, prog_size_reg};
            IDX_POWER_MGMT:     read_value = {clk_div_reg, 4'h0, data_sram_en_reg};
            default:            index_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
            slverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            prdata_reg <= {24'h000000, read_value};
            slverr_reg <= !index_hit || (paddr[1:0] != 2'h0);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port0_latch_reg   <= PORT_LATCH_RST;
            port2_latch_reg   <= PORT_LATCH_RST;
            pointer0_low_reg  <= POINTER_RST;
            pointer0_high_reg <= POINTER_RST;
            pointer1_low_reg  <= POINTER_RST;
            pointer1_high_reg <= POINTER_RST;
            pointer_sel_reg   <= 1'b0;
            prog_size_reg     <= PROG_SIZE_RST;
            clk_div_reg       <= CLK_DIV_RST;
            data_sram_en_reg  <= DATA_SRAM_RST;
        end else if (apb_write && !slverr_reg) begin
            unique case (reg_index)
                IDX_PORT0_LATCH:    port0_latch_reg   <= pwdata[7:0];
                IDX_POINTER0_LOW:   pointer0_low_reg  <= pwdata[7:0];
                IDX_POINTER0_HIGH:  pointer0_high_reg <= pwdata[7:0];
                IDX_POINTER1_LOW:   pointer1_low_reg  <= pwdata[7:0];
                IDX_POINTER1_HIGH:  pointer1_high_reg <= pwdata[7:0];
                IDX_POINTER_CHOICE: pointer_sel_reg   <= pwdata[POINTER_SEL_BIT];
                IDX_PORT2_LATCH:    port2_latch_reg   <= pwdata[7:0];
                IDX_PROGRAM_SIZE:   prog_size_reg     <= pwdata[PROG_SIZE_WIDTH-1:0];
                IDX_POWER_MGMT: begin
                    clk_div_reg      <= pwdata[CLK_DIV_LSB+1:CLK_DIV_LSB];
                    data_sram_en_reg <= {pwdata[DATA_SRAM_EN_HI], pwdata[DATA_SRAM_EN_LO]};
                end
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_FETCH_ABOVE_SPACE: assert property ( // R1
        accept_fetch && fetch_addr > PROG_SPACE_TOP |=> state_reg == ST_ADDR ##2 !program_fetch_strobe_n)
        else $error("fetch above program space not external");

    AST_FETCH_SIZE_BOUND: assert property ( // R2
        accept_fetch && ({1'b0, fetch_addr} >= prog_limit(prog_size_reg)) |=> state_reg == ST_ADDR && kind_fetch_reg)
        else $error("fetch above configured size not external");

    AST_ADDR_ON_PORTS: assert property ( // R4
        state_reg == ST_ADDR |-> addr_latch_enable && low_addr_data_port_out == bus_addr_reg[7:0]
                                 && high_addr_port_out == bus_addr_reg[15:8])
        else $error("address not on ports 0 and 2");

    AST_PORTS_NOT_GPIO: assert property ( // R5
        state_reg == ST_STROBE |-> high_addr_port_oe_n == 8'h00 && high_addr_port_out == bus_addr_reg[15:8]
                                   && low_addr_data_port_out == bus_wdata_reg)
        else $error("port latch leaked onto bus");

    AST_FORCE_EXTERNAL: assert property ( // R6
        accept_fetch && !force_sync_reg |=> state_reg == ST_ADDR ##6 fetch_done && !fetch_internal)
        else $error("forced fetch not external");

    AST_PROG_STROBE_LEN: assert property ( // R7
        $fell(program_fetch_strobe_n) |-> kind_fetch_reg ##0 !program_fetch_strobe_n [*4] ##1 program_fetch_strobe_n)
        else $error("program strobe width wrong");

    AST_PROG_STROBE_IDLE: assert property ( // R13
        !bus_active || !kind_fetch_reg |-> program_fetch_strobe_n)
        else $error("program strobe low outside fetch");

    AST_SRAM_HIT: assert property ( // R10
        accept_move && sram_enabled && move_addr <= DATA_SRAM_TOP |-> xram_if.req ##1 state_reg == ST_INT ##1 dmove_done)
        else $error("data move in SRAM range left chip");

    AST_MOVE_ABOVE_SRAM: assert property ( // R11
        accept_move && move_addr > DATA_SRAM_TOP |-> !xram_if.req ##1 state_reg == ST_ADDR)
        else $error("data move above SRAM range not external");

    AST_SRAM_OFF: assert property ( // R12
        accept_move && !sram_enabled |=> state_reg == ST_ADDR)
        else $error("data move with SRAM off not external");

    AST_DATA_STROBES: assert property ( // R14
        $fell(data_write_strobe_n) || $fell(data_read_strobe_n) |->
            !kind_fetch_reg && (data_write_strobe_n != data_read_strobe_n) && program_fetch_strobe_n)
        else $error("data strobes wrong");

    COV_EXT_FETCH:  cover property (accept_fetch && !fetch_is_int ##[1:10] fetch_done);
    COV_SRAM_MOVE:  cover property (accept_move && move_is_int ##2 dmove_done);
    COV_EXT_WRITE:  cover property ($fell(data_write_strobe_n));
    COV_SIZE_WRITE: cover property (apb_write && reg_index == IDX_PROGRAM_SIZE);

endmodule

// *** tb/msr_ext_mem.sv ***
/* External ROM and RAM on the multiplexed bus, as seen from the pins.
   Assumes quasi pull-ups hold released port 0 lines high. */
`timescale 1ns/100ps
module msr_ext_mem (
    input  wire logic        pclk,
    input  wire logic        ale,
    input  wire logic        pfs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [7:0]  p0_out,
    input  wire logic [7:0]  p0_oe_n,
    input  wire logic [7:0]  p2_out,
    output logic      [7:0]  p0_pin,
    output logic      [15:0] addr_reg,
    output logic      [7:0]  wr_reg
);
    logic [7:0] drv;
    assign drv = addr_reg[7:0] ^ addr_reg[15:8] ^ 8'h5A;
    always_ff @(posedge pclk) if (ale) addr_reg <= {p2_out, p0_out};
    always_ff @(posedge pclk) if (!wr_n) wr_reg <= p0_pin;
    assign p0_pin = (~p0_oe_n & p0_out) | (p0_oe_n & ((!pfs_n || !rd_n) ? drv : 8'hFF));
endmodule

// *** tb/tb.sv ***
/* Self-checking bench of the memory-space router.
   Assumes the external memory model answers on the pins. */
`timescale 1ns/100ps
module tb;
    import msr_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        fetch_valid = 1'b0, dmove_valid = 1'b0, dmove_write = 1'b0;
    logic        direct_valid = 1'b0, direct_write = 1'b0, external_fetch_force_n = 1'b1;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] fetch_addr = 16'h0, ext_addr, lim;
    logic [7:0]  dmove_wdata = 8'h00, direct_addr = 8'h00, direct_wdata = 8'h00;
    logic [7:0]  fetch_data, dmove_rdata, direct_rdata, low_addr_data_port_in, low_addr_data_port_out;
    logic [7:0]  low_addr_data_port_oe_n, high_addr_port_out, high_addr_port_oe_n, wr_byte;
    logic        pready, pslverr, fetch_done, fetch_internal, dmove_done, err, addr_latch_enable;
    logic        program_fetch_strobe_n, data_write_strobe_n, data_read_strobe_n;
    int          mismatches = 0, check_count = 0, strobe_cnt = 0;

    msr_router dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .fetch_valid, .fetch_addr, .fetch_done, .fetch_internal, .fetch_data, .dmove_valid,
        .dmove_write, .dmove_wdata, .dmove_done, .dmove_rdata, .direct_valid, .direct_write,
        .direct_addr, .direct_wdata, .direct_rdata, .external_fetch_force_n, .program_fetch_strobe_n,
        .addr_latch_enable, .low_addr_data_port_in, .low_addr_data_port_out, .low_addr_data_port_oe_n,
        .high_addr_port_out, .high_addr_port_oe_n, .data_write_strobe_n, .data_read_strobe_n);
    msr_ext_mem ext (.pclk, .ale(addr_latch_enable), .pfs_n(program_fetch_strobe_n),
        .rd_n(data_read_strobe_n), .wr_n(data_write_strobe_n), .p0_out(low_addr_data_port_out),
        .p0_oe_n(low_addr_data_port_oe_n), .p2_out(high_addr_port_out),
        .p0_pin(low_addr_data_port_in), .addr_reg(ext_addr), .wr_reg(wr_byte));

    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) if (!program_fetch_strobe_n || !data_read_strobe_n || !data_write_strobe_n) strobe_cnt++;

    function automatic logic [7:0] ext_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic fetch(input logic [15:0] a, input logic ei);
        @(posedge pclk);
        fetch_valid <= 1'b1;
        fetch_addr <= a;
        strobe_cnt = 0;
        do @(posedge pclk); while (fetch_done !== 1'b1);
        fetch_valid <= 1'b0;
        chk(fetch_internal, ei);
        chk(fetch_data, ei ? 8'h00 : ext_byte(a));
        chk(strobe_cnt, ei ? 0 : STROBE_CYCLES);
        if (!ei) chk(ext_addr, a);
    endtask
    task automatic dmove(input logic w, input logic [15:0] a, input logic [7:0] d, input logic ei);
        apb(1'b1, IDX_POINTER0_LOW, {24'h0, a[7:0]});
        apb(1'b1, IDX_POINTER0_HIGH, {24'h0, a[15:8]});
        @(posedge pclk);
        dmove_valid <= 1'b1;
        dmove_write <= w;
        dmove_wdata <= d;
        strobe_cnt = 0;
        do @(posedge pclk); while (dmove_done !== 1'b1);
        dmove_valid <= 1'b0;
        chk(strobe_cnt, ei ? 0 : STROBE_CYCLES);
        if (!w) chk(dmove_rdata, d);
        if (!ei) chk(ext_addr, a);
        if (!ei && w) chk(wr_byte, d);
    endtask
    task automatic direct(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        direct_valid <= 1'b1;
        direct_write <= w;
        direct_addr <= a;
        direct_wdata <= d;
        @(posedge pclk);
        direct_valid <= 1'b0;
        @(posedge pclk);
        if (!w) chk(direct_rdata, d);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #100000;
        mismatches++;
        report_and_stop;
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, IDX_PROGRAM_SIZE, 32'h0);
        chk(rd, 32'h05);
        apb(1'b0, IDX_POWER_MGMT, 32'h0);
        chk(rd, 32'h40);
        apb(1'b1, 8'h01, 32'h0);
        chk(err, 1'b1);
        for (int c = 0; c < 6; c++) begin
            lim = (c == 0) ? 16'h0000 : (c == 5) ? 16'h4000 : 16'h0400 << (c - 1);
            apb(1'b1, IDX_PROGRAM_SIZE, 32'(c));
            if (c != 0) fetch(lim - 16'h0001, 1'b1);
            fetch(lim, 1'b0);
        end
        fetch(16'h3FFF, 1'b1);
        apb(1'b1, IDX_PROGRAM_SIZE, 32'h03);
        fetch(16'h3FFF, 1'b0);
        apb(1'b1, IDX_PORT2_LATCH, 32'hF0);
        apb(1'b1, IDX_PORT0_LATCH, 32'h0F);
        @(posedge pclk);
        chk({high_addr_port_out, high_addr_port_oe_n}, 32'hF0F0);
        chk({low_addr_data_port_out, low_addr_data_port_oe_n}, 32'h0F0F);
        external_fetch_force_n <= 1'b0;
        repeat (3) @(posedge pclk);
        fetch(16'h0000, 1'b0);
        external_fetch_force_n <= 1'b1;
        repeat (3) @(posedge pclk);
        dmove(1'b1, 16'h03FF, 8'hA5, 1'b0);
        apb(1'b1, IDX_POWER_MGMT, 32'h41);
        dmove(1'b1, 16'h03FF, 8'h3C, 1'b1);
        dmove(1'b0, 16'h03FF, 8'h3C, 1'b1);
        dmove(1'b1, 16'h0000, 8'h22, 1'b1);
        direct(1'b1, 8'h00, 8'h11);
        direct(1'b0, 8'h00, 8'h11);
        dmove(1'b0, 16'h0000, 8'h22, 1'b1);
        apb(1'b1, IDX_POINTER_CHOICE, 32'h01);
        dmove(1'b0, 16'h0400, 8'h22, 1'b1);
        apb(1'b1, IDX_POINTER_CHOICE, 32'h00);
        dmove(1'b1, 16'h0400, 8'h77, 1'b0);
        dmove(1'b0, 16'h0400, ext_byte(16'h0400), 1'b0);
        apb(1'b1, IDX_POWER_MGMT, 32'h40);
        dmove(1'b0, 16'h03FF, ext_byte(16'h03FF), 1'b0);
        report_and_stop;
    end
endmodule
